// >>> uflm_core.v
// Overview of operation
// - Ten sources, three request lines, individually masked.
// - Transmit request while buffer empty and enabled.
// - Done flag once line idle; requests when enabled.
// - Status read then data read clears full.
// - Idle cleared likewise; rearms only after new character.
// - Error flags set with full, never on overrun.
// - Character on full buffer: overrun, data dropped.
// - Receive edge sets flag; write one clears.
// - Nine-bit mode adds ninth bit both ways.
// - Ninth bit copied with byte into shifter.
// - Stop freezes; deep stops lose all registers.
// - Edge detector and wake live in light stop.
// - Loopback on: source bit picks loop/single-wire.
// - Loop mode: transmitter feeds receiver, pin released.
// - Single-wire: receiver on transmit pin, pin released.
// - Direction bit: zero listens, one drives.
// - Single-wire receiver hears own transmitted characters.
//
// The placing of the registers and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ns
`include "uflm_map.vh"

module uflm_core (
	input  wire        sys_clk,
	input  wire        nrst,
	input  wire [2:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	output reg  [31:0] avs_readdata,
	output wire        avs_waitrequest,
	input  wire [1:0]  stop_mode,
	input  wire        tx_take,
	input  wire        tx_core_idle,
	input  wire        tx_serial,
	output reg  [8:0]  tx_shift_data,
	output wire        nine_bit_mode,
	input  wire        rx_done,
	input  wire [8:0]  rx_char,
	input  wire        rx_noise,
	input  wire        rx_framing,
	input  wire        rx_parity,
	input  wire        rx_idle_seen,
	input  wire        rx_break_seen,
	output wire        rx_line,
	output wire        rx_enable,
	input  wire        rxd_in,
	input  wire        txd_in,
	output wire        txd_out,
	output wire        txd_oe_n,
	output wire        rxd_released,
	output reg         tx_irq,
	output reg         rx_irq,
	output reg         err_irq,
	output reg         wake_req
);
	// ****************************************************************
	// Reset release and stop mode decode.
	// ****************************************************************
	reg        rst_s1_reg;   // First reset stage, read only by second.
	reg        rst_s2_reg;   // Released reset used by the design.
	wire       rst_n;        // Design reset, active low.
	wire       run_en;       // Clocks running.
	wire       light_stop;   // Lightest stop, contents kept.
	wire       deep_stop;    // Deep stops, contents lost.

	// Reset is applied at once and released after two edges.
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rst_s1_reg <= 1'b0;
			rst_s2_reg <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_s2_reg <= rst_s1_reg;
		end
	end
	assign rst_n = rst_s2_reg;

	// Any stop freezes the port except edge flag and wake in light stop; deep ones also wipe it.
	assign run_en     = (stop_mode == `UFLM_STOP_RUN);
	assign light_stop = (stop_mode == `UFLM_STOP_LIGHT);
	assign deep_stop  = stop_mode[1];

	// ****************************************************************
	// Avalon-MM slave: one wait cycle, then answer.
	// ****************************************************************
	reg        ack_reg;      // High in the answering cycle.
	wire       acc;          // First cycle of a request.
	wire       do_wr;        // Write takes effect this edge.
	wire       do_rd;        // Read completes this edge.
	wire [7:0] wbyte;        // Written byte.

	assign acc             = (avs_read | avs_write) & ~ack_reg;
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
	assign do_wr           = avs_write & ack_reg;
	assign do_rd           = avs_read & ack_reg;
	assign wbyte           = avs_writedata[7:0];

	// Acknowledge toggles so each request sees one wait cycle.
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= acc;
		end
	end

	// ****************************************************************
	// Control registers.
	// ****************************************************************
	reg  [7:0] ctrl_reg;     // Enables, receiver on, nine-bit select.
	reg  [6:0] ctrl3_reg;    // Ninth bit, direction, loop, error enables.
	reg  [7:0] ctrl4_reg;    // Break and edge enables, source select.
	reg  [7:0] tx_buf_reg;   // Transmit data buffer.
	reg        rx_nine_reg;  // Received ninth bit.
	reg  [7:0] rx_buf_reg;   // Received data byte.
	wire       wr_ctrl;
	wire       wr_ctrl3;
	wire       wr_ctrl4;
	wire       wr_data;
	wire       rd_stat1;
	wire       rd_data;

	assign wr_ctrl  = do_wr & run_en & (avs_address == `UFLM_IDX_CTRL);
	assign wr_ctrl3 = do_wr & run_en & (avs_address == `UFLM_IDX_CTRL3);
	assign wr_ctrl4 = do_wr & run_en & (avs_address == `UFLM_IDX_CTRL4);
	assign wr_data  = do_wr & run_en & (avs_address == `UFLM_IDX_DATA);
	assign rd_stat1 = do_rd & run_en & (avs_address == `UFLM_IDX_STAT1);
	assign rd_data  = do_rd & run_en & (avs_address == `UFLM_IDX_DATA);

	// Software-written fields; lost in deep stop.
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg   <= `UFLM_RST_BYTE;
			ctrl3_reg  <= 7'h00;
			ctrl4_reg  <= `UFLM_RST_BYTE;
			tx_buf_reg <= `UFLM_RST_BYTE;
		end else if (deep_stop) begin
			ctrl_reg   <= `UFLM_RST_BYTE;
			ctrl3_reg  <= 7'h00;
			ctrl4_reg  <= `UFLM_RST_BYTE;
			tx_buf_reg <= `UFLM_RST_BYTE;
		end else begin
			if (wr_ctrl) begin
				ctrl_reg <= wbyte;
			end
			// The ninth bit is taken from this write.
			if (wr_ctrl3) begin
				ctrl3_reg <= wbyte[6:0];
			end
			if (wr_ctrl4) begin
				ctrl4_reg <= wbyte;
			end
			if (wr_data) begin
				tx_buf_reg <= wbyte;
			end
		end
	end

	wire tbie       = ctrl_reg[`UFLM_CTRL_TBIE];
	wire tdie       = ctrl_reg[`UFLM_CTRL_TDIE];
	wire rie        = ctrl_reg[`UFLM_CTRL_RIE];
	wire ilie       = ctrl_reg[`UFLM_CTRL_ILIE];
	wire rx_on      = ctrl_reg[`UFLM_CTRL_RXON];
	wire tx_ninth_bit          = ctrl3_reg[`UFLM_C3_TX9];
	wire single_wire_direction = ctrl3_reg[`UFLM_C3_DIR];
	wire loopback_enable       = ctrl3_reg[`UFLM_C3_LOOP];
	wire receiver_source_select = ctrl4_reg[`UFLM_C4_SRC];
	wire rx_edge_irq_enable    = ctrl4_reg[`UFLM_C4_EDIE];

	assign nine_bit_mode = ctrl_reg[`UFLM_CTRL_NINE];
	assign rx_enable     = rx_on;

	// ****************************************************************
	// Line routing: normal, loop and single-wire.
	// ****************************************************************
	wire loop_mode;   // Internal loop selected.
	wire sw_mode;     // Single-wire selected.

	assign loop_mode = loopback_enable & ~receiver_source_select;
	assign sw_mode   = loopback_enable & receiver_source_select;

	// Loop feeds transmitter to receiver; single-wire listens on the
	// pin or, when driving, hears its own output.
	assign rx_line = loop_mode ? tx_serial :
		sw_mode ? (single_wire_direction ? tx_serial : txd_in) : rxd_in;

	// Pin driven except in single-wire listen.
	assign txd_out      = tx_serial;
	assign txd_oe_n     = sw_mode & ~single_wire_direction;
	assign rxd_released = loopback_enable;

	// ****************************************************************
	// Status flags.
	// ****************************************************************
	wire tx_buffer_empty_flag;
	reg  tx_done_flag;
	wire rx_full_flag;
	wire idle_flag;
	wire overrun_flag;
	wire noise_flag;
	wire framing_error_flag;
	wire parity_error_flag;
	wire rx_edge_flag;
	wire break_detect_flag;
	reg  tx_arm_reg;     // Status seen with transmit flags up.
	reg  rx_arm_reg;     // Status seen with receive flags up.
	reg  idle_armed_reg; // Idle may set again.
	wire rx_accept;      // Character moves into the buffer.
	wire rx_lost;        // Character dropped to overrun.
	wire rx_clear;       // Status-then-data read completed.
	wire tx_clear;       // Status-then-data write completed.
	wire edge_fall;      // Active edge on the receive source.
	wire edge_live;      // Edge detector powered.
	wire wr_stat2;

	// A full buffer or pending framing error blocks new data.
	assign rx_accept = run_en & rx_done & ~rx_full_flag & ~framing_error_flag;
	assign rx_lost   = run_en & rx_done & rx_full_flag;
	assign rx_clear  = rd_data & rx_arm_reg;
	assign tx_clear  = wr_data & tx_arm_reg;
	assign wr_stat2  = do_wr & run_en & (avs_address == `UFLM_IDX_STAT2);

	// Remember a status read that saw flags set.
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_arm_reg <= 1'b0;
			tx_arm_reg <= 1'b0;
		end else if (deep_stop) begin
			rx_arm_reg <= 1'b0;
			tx_arm_reg <= 1'b0;
		end else begin
			if (rd_stat1) begin
				rx_arm_reg <= rx_full_flag | idle_flag;
			end else if (rd_data) begin
				rx_arm_reg <= 1'b0;
			end
			if (rd_stat1) begin
				tx_arm_reg <= tx_buffer_empty_flag | tx_done_flag;
			end else if (wr_data) begin
				tx_arm_reg <= 1'b0;
			end
		end
	end

	// Buffer empty sets when the shifter takes the byte.
	uflm_flag #(.RESET_VAL(1'b1)) u_tbe (
		.clk   (sys_clk),
		.rst_n (rst_n),
		.wipe  (deep_stop),
		.set   (run_en & tx_take),
		.clr   (tx_clear),
		.q     (tx_buffer_empty_flag)
	);

	// Done only with the buffer empty and the line idle.
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_done_flag <= 1'b1;
		end else if (deep_stop) begin
			tx_done_flag <= 1'b1;
		end else if (run_en) begin
			if (tx_buffer_empty_flag & tx_core_idle & ~tx_take) begin
				tx_done_flag <= 1'b1;
			end else if (tx_clear | ~tx_core_idle) begin
				tx_done_flag <= 1'b0;
			end
		end
	end

	// Byte and ninth bit move to the shifter together.
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_shift_data <= `UFLM_RST_DATA;
		end else if (deep_stop) begin
			tx_shift_data <= `UFLM_RST_DATA;
		end else if (run_en & tx_take) begin
			tx_shift_data <= {tx_ninth_bit & nine_bit_mode, tx_buf_reg};
		end
	end

	// Received byte and ninth bit are stored on accept.
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_buf_reg  <= `UFLM_RST_BYTE;
			rx_nine_reg <= 1'b0;
		end else if (deep_stop) begin
			rx_buf_reg  <= `UFLM_RST_BYTE;
			rx_nine_reg <= 1'b0;
		end else if (rx_accept) begin
			rx_buf_reg  <= rx_char[7:0];
			rx_nine_reg <= rx_char[8] & nine_bit_mode;
		end
	end

	uflm_flag u_full (
		.clk   (sys_clk),
		.rst_n (rst_n),
		.wipe  (deep_stop),
		.set   (rx_accept),
		.clr   (rx_clear),
		.q     (rx_full_flag)
	);

	// Idle rearms only when a new character has set full.
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			idle_armed_reg <= 1'b1;
		end else if (deep_stop) begin
			idle_armed_reg <= 1'b1;
		end else if (rx_accept) begin
			idle_armed_reg <= 1'b1;
		end else if (rx_clear & idle_flag) begin
			idle_armed_reg <= 1'b0;
		end
	end

	uflm_flag u_idle (
		.clk   (sys_clk),
		.rst_n (rst_n),
		.wipe  (deep_stop),
		.set   (run_en & rx_idle_seen & idle_armed_reg),
		.clr   (rx_clear),
		.q     (idle_flag)
	);

	uflm_flag u_ovr (
		.clk   (sys_clk),
		.rst_n (rst_n),
		.wipe  (deep_stop),
		.set   (rx_lost),
		.clr   (rx_clear),
		.q     (overrun_flag)
	);

	// Errors ride with the accepted character only.
	uflm_flag u_nz (
		.clk   (sys_clk),
		.rst_n (rst_n),
		.wipe  (deep_stop),
		.set   (rx_accept & rx_noise),
		.clr   (rx_clear),
		.q     (noise_flag)
	);

	uflm_flag u_fr (
		.clk   (sys_clk),
		.rst_n (rst_n),
		.wipe  (deep_stop),
		.set   (rx_accept & rx_framing),
		.clr   (rx_clear),
		.q     (framing_error_flag)
	);

	uflm_flag u_pa (
		.clk   (sys_clk),
		.rst_n (rst_n),
		.wipe  (deep_stop),
		.set   (rx_accept & rx_parity),
		.clr   (rx_clear),
		.q     (parity_error_flag)
	);

	// Edge detector runs in run and light stop only.
	assign edge_live = rx_on & (run_en | light_stop);

	uflm_fall_det u_edge (
		.clk    (sys_clk),
		.rst_n  (rst_n),
		.enable (edge_live),
		.din    (rx_line),
		.fall   (edge_fall)
	);

	uflm_flag u_edgef (
		.clk   (sys_clk),
		.rst_n (rst_n),
		.wipe  (deep_stop),
		.set   (edge_fall),
		.clr   (wr_stat2 & wbyte[`UFLM_S2_EDGE]),
		.q     (rx_edge_flag)
	);

	uflm_flag u_brk (
		.clk   (sys_clk),
		.rst_n (rst_n),
		.wipe  (deep_stop),
		.set   (run_en & rx_break_seen),
		.clr   (wr_stat2 & wbyte[`UFLM_S2_BRK]),
		.q     (break_detect_flag)
	);

	// ****************************************************************
	// Request lines and wakeup.
	// ****************************************************************
	wire tx_req;
	wire rx_req;
	wire err_req;

	// Masks gate requests only; flags stay readable.
	assign tx_req = (tx_buffer_empty_flag & tbie) | (tx_done_flag & tdie);
	assign rx_req = (rx_full_flag & rie) | (idle_flag & ilie) |
		(rx_edge_flag & rx_edge_irq_enable) |
		(break_detect_flag & ctrl4_reg[`UFLM_C4_BKIE]);
	assign err_req = (overrun_flag & ctrl3_reg[`UFLM_C3_ORIE]) |
		(noise_flag & ctrl3_reg[`UFLM_C3_NEIE]) |
		(framing_error_flag & ctrl3_reg[`UFLM_C3_FEIE]) |
		(parity_error_flag & ctrl3_reg[`UFLM_C3_PEIE]);

	// Requests hold while any enabled flag stays set.
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_irq   <= 1'b0;
			rx_irq   <= 1'b0;
			err_irq  <= 1'b0;
			wake_req <= 1'b0;
		end else begin
			tx_irq   <= tx_req;
			rx_irq   <= rx_req;
			err_irq  <= err_req;
			wake_req <= light_stop & rx_edge_flag & rx_edge_irq_enable;
		end
	end

	// ****************************************************************
	// Read data, captured in the wait cycle.
	// ****************************************************************
	reg [7:0] rbyte;

	// Selects the addressed register; unmapped reads as zero.
	always @* begin
		rbyte = 8'h00;
		case (avs_address)
			`UFLM_IDX_CTRL:  rbyte = ctrl_reg;
			`UFLM_IDX_STAT1: rbyte = {tx_buffer_empty_flag, tx_done_flag,
				rx_full_flag, idle_flag, overrun_flag, noise_flag,
				framing_error_flag, parity_error_flag};
			`UFLM_IDX_STAT2: rbyte = {break_detect_flag, rx_edge_flag, 6'h00};
			`UFLM_IDX_CTRL3: rbyte = {rx_nine_reg, ctrl3_reg};
			`UFLM_IDX_CTRL4: rbyte = ctrl4_reg;
			`UFLM_IDX_DATA:  rbyte = rx_buf_reg;
			default:         rbyte = 8'h00;
		endcase
	end

	// Read data stands from the answer edge onward.
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_readdata <= 32'h0000_0000;
		end else if (acc & avs_read) begin
			avs_readdata <= {24'h00_0000, rbyte};
		end
	end

endmodule // uflm_core

// >>> uflm_map.vh
`ifndef UFLM_MAP_VH
`define UFLM_MAP_VH

// ****************************************************************
// Register word indices on the Avalon-MM slave.
// ****************************************************************
`define UFLM_IDX_CTRL    3'h0
`define UFLM_IDX_STAT1   3'h1
`define UFLM_IDX_STAT2   3'h2
`define UFLM_IDX_CTRL3   3'h3
`define UFLM_IDX_CTRL4   3'h4
`define UFLM_IDX_DATA    3'h5

// ****************************************************************
// Control register field positions.
// ****************************************************************
`define UFLM_CTRL_TBIE   7
`define UFLM_CTRL_TDIE   6
`define UFLM_CTRL_RIE    5
`define UFLM_CTRL_ILIE   4
`define UFLM_CTRL_RXON   2
`define UFLM_CTRL_NINE   0

// ****************************************************************
// Status one register field positions.
// ****************************************************************
`define UFLM_S1_TBE      7
`define UFLM_S1_TD       6
`define UFLM_S1_RX_FULL_FLAG     5
`define UFLM_S1_IDLE     4
`define UFLM_S1_OVR      3
`define UFLM_S1_NZ       2
`define UFLM_S1_FR       1
`define UFLM_S1_PA       0

// ****************************************************************
// Status two register field positions (write one to clear).
// ****************************************************************
`define UFLM_S2_BRK      7
`define UFLM_S2_EDGE     6

// ****************************************************************
// Control three register field positions.
// ****************************************************************
`define UFLM_C3_RX9      7
`define UFLM_C3_TX9      6
`define UFLM_C3_DIR      5
`define UFLM_C3_LOOP     4
`define UFLM_C3_ORIE     3
`define UFLM_C3_NEIE     2
`define UFLM_C3_FEIE     1
`define UFLM_C3_PEIE     0

// ****************************************************************
// Control four register field positions.
// ****************************************************************
`define UFLM_C4_BKIE     7
`define UFLM_C4_EDIE     6
`define UFLM_C4_SRC      0

// ****************************************************************
// Reset values and stop mode codes.
// ****************************************************************
`define UFLM_RST_BYTE    8'h00
`define UFLM_RST_DATA    9'h000
`define UFLM_STOP_RUN    2'h0
`define UFLM_STOP_LIGHT  2'h1

`endif

// >>> uflm_flag.v
`timescale 1ns/1ns
// ****************************************************************
// Sticky flag cell: a set in the same cycle as a clear wins.
// ****************************************************************
module uflm_flag #(
	parameter RESET_VAL = 1'b0
) (
	input  wire clk,
	input  wire rst_n,
	input  wire wipe,
	input  wire set,
	input  wire clr,
	output reg  q
);
	// Wipe models loss of contents, then set, then clear.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= RESET_VAL;
		end else if (wipe) begin
			q <= RESET_VAL;
		end else if (set) begin
			q <= 1'b1;
		end else if (clr) begin
			q <= 1'b0;
		end
	end
endmodule // uflm_flag

// >>> uflm_fall_det.v
`timescale 1ns/1ns
// ****************************************************************
// Falling edge detector for the idle-high receive line.
// ****************************************************************
module uflm_fall_det (
	input  wire clk,
	input  wire rst_n,
	input  wire enable,
	input  wire din,
	output wire fall
);
	reg prev_reg; // Line level one cycle ago, idle high.

	// Track the line every cycle so no stale edge appears later.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_reg <= 1'b1;
		end else begin
			prev_reg <= din;
		end
	end

	// A high-to-low step counts only while enabled.
	assign fall = enable & prev_reg & ~din;
endmodule // uflm_fall_det

// >>> uflm_remote_node.sv
`timescale 1ns/1ns
// ****************************************************************
// Remote serial node: idles high and pulls its line low on request.
// ****************************************************************
module uflm_remote_node (
	input  logic drop_req,
	input  logic txd_oe_n,
	input  logic txd_out,
	output logic rxd_pin,
	output logic txd_pin
);
	// The node drives the shared pin only while the device listens.
	assign txd_pin = txd_oe_n ? ~drop_req : txd_out;
	// The node's own transmit line feeds the receive pin.
	assign rxd_pin = ~drop_req;
endmodule // uflm_remote_node

// >>> uflm_core_asserts.sv
`timescale 1ns/1ns
// ****************************************************************
// Port checks of the line modes, stop modes and ninth bit.
// ****************************************************************
module uflm_core_asserts (
	input logic       sys_clk,
	input logic       nrst,
	input logic [1:0] stop_mode,
	input logic       tx_take,
	input logic       tx_serial,
	input logic [8:0] tx_shift_data,
	input logic       nine_bit_mode,
	input logic       rx_line,
	input logic       rx_enable,
	input logic       rxd_in,
	input logic       txd_in,
	input logic       txd_out,
	input logic       txd_oe_n,
	input logic       rxd_released,
	input logic       tx_irq,
	input logic       rx_irq,
	input logic       err_irq,
	input logic       wake_req
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	// Pin inputs reach rx_line with no synchroniser; levels are still held four cycles first.
	AST_NORMAL_SRC: assert property ((!rxd_released && !rxd_in)[*4] |-> !rx_line && !txd_oe_n)
		else $error("receiver not fed from the receive pin");
	AST_LOOP_SRC: assert property ((rxd_released && !txd_oe_n && !tx_serial)[*4] |-> !rx_line)
		else $error("receiver not fed from the transmitter");
	AST_LISTEN_SRC: assert property ((rxd_released && txd_oe_n && !txd_in)[*4] |-> !rx_line)
		else $error("receiver not fed from the transmit pin");
	AST_PIN_DRIVE: assert property (!txd_oe_n |-> txd_out == tx_serial)
		else $error("driven pin differs from transmitter");
	AST_EIGHT_BIT: assert property (stop_mode == 2'h0 && tx_take && !nine_bit_mode |=> !tx_shift_data[8])
		else $error("ninth bit loaded outside nine-bit mode");
	AST_DEEP_WIPE: assert property (stop_mode[1][*3] |-> !(tx_irq || rx_irq || err_irq || wake_req))
		else $error("request alive in deep stop");
	AST_LIGHT_HOLD: assert property (stop_mode == 2'h1 |=> $stable({nine_bit_mode, rx_enable}))
		else $error("control changed in light stop");
	AST_WAKE_LIGHT: assert property (wake_req |-> $past(stop_mode) == 2'h1)
		else $error("wake outside light stop");
	// Main scenarios that must be reached.
	cover property (rxd_released && txd_oe_n && !txd_in);
	cover property (wake_req);
	cover property (tx_take && nine_bit_mode);
endmodule // uflm_core_asserts

bind uflm_core uflm_core_asserts u_chk (
	.sys_clk(sys_clk), .nrst(nrst), .stop_mode(stop_mode), .tx_take(tx_take),
	.tx_serial(tx_serial), .tx_shift_data(tx_shift_data), .nine_bit_mode(nine_bit_mode),
	.rx_line(rx_line), .rx_enable(rx_enable), .rxd_in(rxd_in), .txd_in(txd_in),
	.txd_out(txd_out), .txd_oe_n(txd_oe_n), .rxd_released(rxd_released), .tx_irq(tx_irq),
	.rx_irq(rx_irq), .err_irq(err_irq), .wake_req(wake_req)
);

// >>> uflm_core_tb_top.sv
`timescale 1ns/1ns
`include "uflm_map.vh"
module uflm_core_tb_top;
	logic        sys_clk, nrst, avs_read, avs_write, tx_take, tx_core_idle, tx_serial;
	logic        rx_done, rx_noise, rx_framing, rx_parity, rx_idle_seen, drop_req, rx_break_seen;
	logic [2:0]  avs_address;
	logic [31:0] avs_writedata;
	logic [1:0]  stop_mode;
	logic [8:0]  rx_char;
	logic [7:0]  rd;
	wire  [31:0] avs_readdata;
	wire  [8:0]  tx_shift_data;
	wire         avs_waitrequest, nine_bit_mode, rx_line, rx_enable, txd_out, txd_oe_n;
	wire         rxd_released, tx_irq, rx_irq, err_irq, wake_req, rxd_pin, txd_pin;
	int          n_mismatch, n_tests, cyc;

	uflm_core u_dut (
		.sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .stop_mode(stop_mode), .tx_take(tx_take),
		.tx_core_idle(tx_core_idle), .tx_serial(tx_serial), .tx_shift_data(tx_shift_data),
		.nine_bit_mode(nine_bit_mode), .rx_done(rx_done), .rx_char(rx_char),
		.rx_noise(rx_noise), .rx_framing(rx_framing), .rx_parity(rx_parity),
		.rx_idle_seen(rx_idle_seen), .rx_break_seen(rx_break_seen), .rx_line(rx_line),
		.rx_enable(rx_enable), .rxd_in(rxd_pin), .txd_in(txd_pin), .txd_out(txd_out),
		.txd_oe_n(txd_oe_n), .rxd_released(rxd_released), .tx_irq(tx_irq), .rx_irq(rx_irq),
		.err_irq(err_irq), .wake_req(wake_req)
	);
	uflm_remote_node u_node (
		.drop_req(drop_req), .txd_oe_n(txd_oe_n), .txd_out(txd_out),
		.rxd_pin(rxd_pin), .txd_pin(txd_pin)
	);

	// ****************************************************************
	// Shared helpers.
	// ****************************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One Avalon transfer, held until waitrequest is seen low.
	task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= {24'h00_0000, d};
		avs_read <= !w;
		avs_write <= w;
		do @(posedge sys_clk);
		while (avs_waitrequest !== 1'h0);
		rd = avs_readdata[7:0];
		avs_read <= 1'h0;
		avs_write <= 1'h0;
	endtask
	task automatic rdchk(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
		bus(1'h0, a, 8'h00);
		chk(rd & m, e);
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge sys_clk);
	endtask
	task automatic take;
		@(posedge sys_clk);
		tx_take <= 1'h1;
		@(posedge sys_clk);
		tx_take <= 1'h0;
		tick(1);
	endtask
	task automatic idle_pulse;
		@(posedge sys_clk);
		rx_idle_seen <= 1'h1;
		@(posedge sys_clk);
		rx_idle_seen <= 1'h0;
		tick(1);
	endtask
	task automatic rx_feed(input logic [8:0] c, input logic [2:0] e);
		@(posedge sys_clk);
		rx_char <= c;
		{rx_noise, rx_framing, rx_parity} <= e;
		rx_done <= 1'h1;
		@(posedge sys_clk);
		rx_done <= 1'h0;
		{rx_noise, rx_framing, rx_parity} <= 3'h0;
		tick(2);
	endtask

	// ****************************************************************
	// Scenarios.
	// ****************************************************************
	task automatic t_tx;
		drop_req <= 1'h1;
		tick(5);
		chk(rx_line, 1'h0);
		drop_req <= 1'h0;
		rdchk(`UFLM_IDX_STAT1, 8'hFF, 8'hC0);
		rdchk(3'h6, 8'hFF, 8'h00);
		bus(1'h1, `UFLM_IDX_CTRL, 8'h80);
		tick(2);
		chk(tx_irq, 1'h1);
		bus(1'h1, `UFLM_IDX_CTRL, 8'h41);
		tick(2);
		chk(tx_irq, 1'h1);
		bus(1'h1, `UFLM_IDX_CTRL3, 8'h40);
		tx_core_idle <= 1'h0;
		rdchk(`UFLM_IDX_STAT1, 8'hC0, 8'h80);
		bus(1'h1, `UFLM_IDX_DATA, 8'hA5);
		rdchk(`UFLM_IDX_STAT1, 8'hC0, 8'h00);
		chk(tx_irq, 1'h0);
		take;
		chk(tx_shift_data, 9'h1A5);
		bus(1'h1, `UFLM_IDX_CTRL, 8'h40);
		bus(1'h1, `UFLM_IDX_DATA, 8'h3C);
		take;
		chk(tx_shift_data, 9'h03C);
		tx_core_idle <= 1'h1;
		bus(1'h1, `UFLM_IDX_CTRL, 8'h00);
		tick(2);
		chk(tx_irq, 1'h0);
		rdchk(`UFLM_IDX_STAT1, 8'hC0, 8'hC0);
	endtask
	task automatic t_rx;
		bus(1'h1, `UFLM_IDX_CTRL, 8'h25);
		bus(1'h1, `UFLM_IDX_CTRL3, 8'h08);
		chk({nine_bit_mode, rx_enable}, 2'h3);
		rx_feed(9'h15A, 3'h4);
		chk(rx_irq, 1'h1);
		rdchk(`UFLM_IDX_STAT1, 8'h3F, 8'h24);
		rx_feed(9'h0FF, 3'h1);
		chk(err_irq, 1'h1);
		rdchk(`UFLM_IDX_STAT1, 8'h3F, 8'h2C);
		rdchk(`UFLM_IDX_CTRL3, 8'h80, 8'h80);
		rdchk(`UFLM_IDX_DATA, 8'hFF, 8'h5A);
		rdchk(`UFLM_IDX_STAT1, 8'h3F, 8'h00);
		idle_pulse;
		rdchk(`UFLM_IDX_STAT1, 8'h10, 8'h10);
		rdchk(`UFLM_IDX_DATA, 8'hFF, 8'h5A);
		rdchk(`UFLM_IDX_STAT1, 8'h10, 8'h00);
		idle_pulse;
		rdchk(`UFLM_IDX_STAT1, 8'h10, 8'h00);
		rx_break_seen <= 1'h1;
		tick(1);
		rx_break_seen <= 1'h0;
		rdchk(`UFLM_IDX_STAT2, 8'h80, 8'h80);
	endtask
	task automatic t_modes;
		bus(1'h1, `UFLM_IDX_CTRL3, 8'h10);
		tx_serial <= 1'h0;
		tick(5);
		chk({rxd_released, txd_oe_n, rx_line}, 3'h4);
		tx_serial <= 1'h1;
		bus(1'h1, `UFLM_IDX_CTRL4, 8'h01);
		bus(1'h1, `UFLM_IDX_STAT2, 8'hC0);
		rdchk(`UFLM_IDX_STAT2, 8'h40, 8'h00);
		drop_req <= 1'h1;
		tick(5);
		chk({txd_oe_n, rx_line}, 2'h2);
		rdchk(`UFLM_IDX_STAT2, 8'h40, 8'h40);
		drop_req <= 1'h0;
		bus(1'h1, `UFLM_IDX_STAT2, 8'h40);
		rdchk(`UFLM_IDX_STAT2, 8'h40, 8'h00);
		bus(1'h1, `UFLM_IDX_CTRL3, 8'h30);
		tx_serial <= 1'h0;
		tick(5);
		chk({txd_oe_n, txd_pin, rx_line}, 3'h0);
		tx_serial <= 1'h1;
	endtask
	task automatic t_stop;
		bus(1'h1, `UFLM_IDX_CTRL3, 8'h10);
		bus(1'h1, `UFLM_IDX_CTRL4, 8'h41);
		bus(1'h1, `UFLM_IDX_STAT2, 8'hC0);
		stop_mode <= `UFLM_STOP_LIGHT;
		drop_req <= 1'h1;
		tick(5);
		chk(wake_req, 1'h1);
		drop_req <= 1'h0;
		rdchk(`UFLM_IDX_CTRL4, 8'hFF, 8'h41);
		stop_mode <= 2'h2;
		tick(3);
		stop_mode <= `UFLM_STOP_RUN;
		tick(3);
		rdchk(`UFLM_IDX_CTRL4, 8'hFF, 8'h00);
		rdchk(`UFLM_IDX_STAT1, 8'hFF, 8'hC0);
	endtask

	// ****************************************************************
	// Verdict, clock, timeout and main sequence.
	// ****************************************************************
	task automatic summarize;
		$display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		sys_clk = 1'h0;
		forever #4 sys_clk = ~sys_clk;
	end
	// A hung bus or a stuck task ends the run here.
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_mismatch++;
			summarize;
		end
	end
	initial begin
		{nrst, avs_read, avs_write, tx_take, rx_done, rx_noise, rx_framing} = 7'h00;
		{rx_parity, rx_idle_seen, rx_break_seen, drop_req, avs_address, stop_mode, rx_char} = 18'h0_0000;
		{tx_core_idle, tx_serial, avs_writedata} = {2'h3, 32'h0000_0000};
		repeat (10) @(posedge sys_clk);
		nrst <= 1'h1;
		repeat (3) @(posedge sys_clk);
		t_tx;
		t_rx;
		t_modes;
		t_stop;
		summarize;
	end
endmodule // uflm_core_tb_top
